// ---- hw/dio_pkg.sv ----
package dio_pkg;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_KHZ = 200_000;
  localparam int WD_TICK_MS = 100;
  localparam int WD_TICK_CYC = WD_TICK_MS * CLK_KHZ;
  localparam int LPF_SHIFT = 4;
  localparam int LPF_STEP_CYC = WD_TICK_CYC >> LPF_SHIFT;

  // ***************************************************************
  // Register offsets
  // ***************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_WDT = 8'h04;
  localparam logic [7:0] OFS_FILT = 8'h08;
  localparam logic [7:0] OFS_DIAG = 8'h0C;
  localparam logic [7:0] OFS_MON_A = 8'h10;
  localparam logic [7:0] OFS_MON_B = 8'h14;
  localparam logic [7:0] OFS_OSIM = 8'h18;
  localparam logic [7:0] OFS_AOSIM = 8'h1C;
  localparam logic [7:0] OFS_CHA = 8'h20;
  localparam logic [7:0] OFS_CHB = 8'h30;
  localparam logic [7:0] OFS_FREQ_A = 8'h40;
  localparam logic [7:0] OFS_FREQ_B = 8'h44;
  localparam int CH_V = 0;
  localparam int CH_S = 4;
  localparam int CH_G = 8;
  localparam int CTRL_CLR_BIT = 4;

  // ***************************************************************
  // Reset values and limits
  // ***************************************************************
  localparam logic [15:0] RST_WDT = 16'h0064;
  localparam logic [6:0] RST_FILT = 7'h0A;
  localparam logic [6:0] FILT_MIN = 7'h01;
  localparam logic [6:0] FILT_MAX = 7'h64;
  localparam logic [9:0] RST_LOWV_A = 10'h004;
  localparam logic [9:0] RST_LOWV_B = 10'h001;
  localparam logic [9:0] RST_HIGHV = 10'h3E8;
  localparam logic [7:0] RST_LOWSET = 8'h64;
  localparam logic [7:0] RST_HIGHSET = 8'hC8;
  localparam logic [6:0] RST_GAIN = 7'h0A;
  localparam logic [8:0] RST_TC = 9'h001;
  localparam logic [9:0] PCT_ZERO = 10'h064;
  localparam logic [10:0] VOLT_SCALE = 11'h3E9;
  localparam logic [11:0] AO_MAX = 12'hFFF;

  typedef struct packed {
    logic [9:0] lowv;
    logic [9:0] highv;
    logic [7:0] lowset;
    logic [7:0] highset;
    logic [6:0] gain;
    logic [8:0] tc;
  } dio_chan_cfg_t;

  typedef struct packed {
    logic [7:0] inv_mask;
    logic stop_mode;
    logic estop_pol;
    logic coast_pol;
  } dio_ctrl_t;

  typedef enum logic [1:0] {
    WD_RUN = 2'b00,
    WD_DECEL = 2'b01,
    WD_TRIP = 2'b10
  } dio_wd_state_t;

endpackage

// ---- hw/dio_terminal_cond.sv ----
// The placing of the registers and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps

// ***************************************************************
// Analog channel: filter, clamp, map, gain, benchmark
// ***************************************************************
module dio_chan
  import dio_pkg::*;
#(
  parameter int LPF_STEP = LPF_STEP_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [11:0] adc,
  input wire dio_chan_cfg_t cfg,
  input wire logic [15:0] bench,
  output logic signed [23:0] freq
);
  logic [20:0] pre, next_pre;
  logic [8:0] tcc, next_tcc;
  logic [15:0] acc, next_acc;
  logic signed [23:0] next_freq;
  logic [22:0] vmul;
  logic [9:0] v;
  logic [17:0] num;
  logic [17:0] quo;
  logic [8:0] pct_u;
  logic signed [9:0] pct;
  logic signed [40:0] prod;

  always_comb begin
    next_pre = pre + 21'd1;
    next_tcc = tcc;
    next_acc = acc;
    if (pre >= 21'(LPF_STEP - 1)) begin
      next_pre = '0;
      next_tcc = tcc + 9'd1;
      // Time constant scales the update interval; step is 1/16 of the gap
      if (tcc + 9'd1 >= cfg.tc) begin
        next_tcc = '0;
        next_acc = acc + 16'($signed({1'b0, adc, 4'h0} - {1'b0, acc}) >>> LPF_SHIFT);
      end
    end
    vmul = 23'(acc[15:4]) * 23'(VOLT_SCALE);
    v = vmul[21:12];
    num = 18'(v - cfg.lowv) * 18'(cfg.highset - cfg.lowset);
    quo = (cfg.highv > cfg.lowv) ? num / 18'(cfg.highv - cfg.lowv) : '0;
    if (v <= cfg.lowv) begin
      pct_u = {1'b0, cfg.lowset};
    end else if (v >= cfg.highv) begin
      pct_u = {1'b0, cfg.highset};
    end else begin
      pct_u = 9'({1'b0, cfg.lowset} + quo);
    end
    pct = $signed({1'b0, pct_u}) - $signed(PCT_ZERO);
    // Gain is in tenths and percent in hundredths, hence the 1000
    prod = pct * $signed({1'b0, cfg.gain}) * $signed({1'b0, bench});
    next_freq = 24'(prod / 41'sd1000);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre <= '0;
      tcc <= '0;
      acc <= '0;
      freq <= '0;
    end else begin
      pre <= next_pre;
      tcc <= next_tcc;
      acc <= next_acc;
      freq <= next_freq;
    end
  end
endmodule // dio_chan

// ***************************************************************
// Top: terminal conditioning with AHB-Lite registers
// ***************************************************************
module dio_terminal_cond
  import dio_pkg::*;
#(
  parameter int WD_TICK = WD_TICK_CYC,
  parameter int LPF_STEP = LPF_STEP_CYC,
  parameter int NUM_IN = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [NUM_IN-1:0] digital_input_n,
  input wire logic coast_stop_pin,
  input wire logic emergency_stop_pin,
  input wire logic watchdog_pulse_pin,
  input wire logic [11:0] analog_input_one,
  input wire logic [11:0] analog_input_two,
  input wire logic drive_stopped,
  input wire logic combined_speed_mode,
  input wire logic [15:0] main_frequency,
  input wire logic [15:0] max_frequency_setting,
  input wire logic run_direction_setting,
  input wire logic relay_normal,
  input wire logic do_one_normal,
  input wire logic do_two_normal,
  input wire logic [11:0] ao_one_normal,
  input wire logic [11:0] ao_two_normal,
  output logic [NUM_IN-1:0] conditioned_inputs,
  output logic coast_stop_active,
  output logic emergency_stop_active,
  output logic coast_stop_cmd,
  output logic decel_stop_cmd,
  output logic watchdog_trip_code,
  output logic relay_out,
  output logic digital_output_one,
  output logic digital_output_two,
  output logic [11:0] analog_output_one,
  output logic [11:0] analog_output_two,
  output logic signed [23:0] freq_a,
  output logic signed [23:0] freq_b,
  output logic reverse_a,
  output logic reverse_b
);
  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  localparam int NS = NUM_IN + 3;
  logic [NS-1:0] sync1, sync2;
  logic wd_prev;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= '0;
      sync2 <= '0;
      wd_prev <= 1'b0;
    end else begin
      sync1 <= {watchdog_pulse_pin, emergency_stop_pin, coast_stop_pin, digital_input_n};
      sync2 <= sync1;
      wd_prev <= sync2[NS-1];
    end
  end

  // ***************************************************************
  // Register file over AHB-Lite
  // ***************************************************************
  dio_ctrl_t ctrl, next_ctrl;
  logic [15:0] wdt, next_wdt;
  logic [6:0] filt, next_filt;
  logic [4:0] sim_en, next_sim_en;
  logic [2:0] sim_val, next_sim_val;
  logic [11:0] ao_a, next_ao_a, ao_b, next_ao_b;
  dio_chan_cfg_t cha, next_cha, chb, next_chb;
  logic [31:0] next_hrdata;
  logic wr_pend, next_wr_pend;
  logic [7:0] wr_addr, next_wr_addr;
  logic trip_clr;
  logic [7:0] a;

  always_comb begin
    a = haddr[7:0];
    next_wr_pend = hsel && htrans[1] && hready && hwrite;
    next_wr_addr = a;
    next_hrdata = hrdata;
    if (hsel && htrans[1] && hready && !hwrite) begin
      if (a == OFS_CTRL) next_hrdata = {16'h0000, ctrl.inv_mask, 5'h00, ctrl.stop_mode,
                                         ctrl.estop_pol, ctrl.coast_pol};
      else if (a == OFS_WDT) next_hrdata = {16'h0000, wdt};
      else if (a == OFS_FILT) next_hrdata = {25'h0000000, filt};
      else if (a == OFS_DIAG) next_hrdata = {21'h000000, watchdog_trip_code,
                                emergency_stop_active, coast_stop_active, 8'(conditioned_inputs)};
      else if (a == OFS_MON_A) next_hrdata = {20'h00000, analog_input_one};
      else if (a == OFS_MON_B) next_hrdata = {20'h00000, analog_input_two};
      else if (a == OFS_OSIM) next_hrdata = {21'h000000, sim_val, 3'h0, sim_en};
      else if (a == OFS_AOSIM) next_hrdata = {4'h0, ao_b, 4'h0, ao_a};
      else if (a == OFS_CHA + 8'(CH_V)) next_hrdata = {6'h00, cha.highv, 6'h00, cha.lowv};
      else if (a == OFS_CHA + 8'(CH_S)) next_hrdata = {8'h00, cha.highset, 8'h00, cha.lowset};
      else if (a == OFS_CHA + 8'(CH_G)) next_hrdata = {7'h00, cha.tc, 9'h000, cha.gain};
      else if (a == OFS_CHB + 8'(CH_V)) next_hrdata = {6'h00, chb.highv, 6'h00, chb.lowv};
      else if (a == OFS_CHB + 8'(CH_S)) next_hrdata = {8'h00, chb.highset, 8'h00, chb.lowset};
      else if (a == OFS_CHB + 8'(CH_G)) next_hrdata = {7'h00, chb.tc, 9'h000, chb.gain};
      else if (a == OFS_FREQ_A) next_hrdata = {7'h00, reverse_a, freq_a};
      else if (a == OFS_FREQ_B) next_hrdata = {7'h00, reverse_b, freq_b};
      else next_hrdata = '0;
    end
    next_ctrl = ctrl;
    next_wdt = wdt;
    next_filt = filt;
    next_sim_en = sim_en;
    next_sim_val = sim_val;
    next_ao_a = ao_a;
    next_ao_b = ao_b;
    next_cha = cha;
    next_chb = chb;
    trip_clr = 1'b0;
    if (wr_pend) begin
      if (wr_addr == OFS_CTRL) begin
        next_ctrl = {hwdata[15:8], hwdata[2:0]};
        trip_clr = hwdata[CTRL_CLR_BIT];
      end else if (wr_addr == OFS_WDT) begin
        next_wdt = hwdata[15:0];
      end else if (wr_addr == OFS_FILT) begin
        // Counts below the minimum or with bits 6:0 all zero go to the minimum; other out-of-range counts go to the maximum
        if (hwdata[6:0] < FILT_MIN) next_filt = FILT_MIN;
        else if (hwdata[6:0] > FILT_MAX || hwdata[31:7] != '0) next_filt = FILT_MAX;
        else next_filt = hwdata[6:0];
      end else if (wr_addr == OFS_OSIM) begin
        next_sim_en = hwdata[4:0];
        next_sim_val = hwdata[10:8];
      end else if (wr_addr == OFS_AOSIM && drive_stopped) begin
        if (hwdata[0] && ao_a != AO_MAX) next_ao_a = ao_a + 12'h001;
        else if (hwdata[1] && ao_a != 12'h000) next_ao_a = ao_a - 12'h001;
        if (hwdata[2] && ao_b != AO_MAX) next_ao_b = ao_b + 12'h001;
        else if (hwdata[3] && ao_b != 12'h000) next_ao_b = ao_b - 12'h001;
      end else if (wr_addr == OFS_CHA + 8'(CH_V)) begin
        next_cha.lowv = hwdata[9:0];
        next_cha.highv = hwdata[25:16];
      end else if (wr_addr == OFS_CHA + 8'(CH_S)) begin
        next_cha.lowset = hwdata[7:0];
        next_cha.highset = hwdata[23:16];
      end else if (wr_addr == OFS_CHA + 8'(CH_G)) begin
        next_cha.gain = hwdata[6:0];
        next_cha.tc = hwdata[24:16];
      end else if (wr_addr == OFS_CHB + 8'(CH_V)) begin
        next_chb.lowv = hwdata[9:0];
        next_chb.highv = hwdata[25:16];
      end else if (wr_addr == OFS_CHB + 8'(CH_S)) begin
        next_chb.lowset = hwdata[7:0];
        next_chb.highset = hwdata[23:16];
      end else if (wr_addr == OFS_CHB + 8'(CH_G)) begin
        next_chb.gain = hwdata[6:0];
        next_chb.tc = hwdata[24:16];
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= '0;
      wdt <= RST_WDT;
      filt <= RST_FILT;
      sim_en <= '0;
      sim_val <= '0;
      ao_a <= '0;
      ao_b <= '0;
      cha <= {RST_LOWV_A, RST_HIGHV, RST_LOWSET, RST_HIGHSET, RST_GAIN, RST_TC};
      chb <= {RST_LOWV_B, RST_HIGHV, RST_LOWSET, RST_HIGHSET, RST_GAIN, RST_TC};
      hrdata <= '0;
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else begin
      ctrl <= next_ctrl;
      wdt <= next_wdt;
      filt <= next_filt;
      sim_en <= next_sim_en;
      sim_val <= next_sim_val;
      ao_a <= next_ao_a;
      ao_b <= next_ao_b;
      cha <= next_cha;
      chb <= next_chb;
      hrdata <= next_hrdata;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
    end
  end

  // ***************************************************************
  // Digital input filter, inversion, stop terminals
  // ***************************************************************
  logic [6:0] fcnt [NUM_IN];
  logic [6:0] next_fcnt [NUM_IN];
  logic [NUM_IN-1:0] fstate, next_fstate;
  logic next_coast, next_estop;

  always_comb begin
    for (int i = 0; i < NUM_IN; i++) begin
      next_fcnt[i] = '0;
      next_fstate[i] = fstate[i];
      if (sync2[i] != fstate[i]) begin
        next_fcnt[i] = fcnt[i] + 7'h01;
        if (fcnt[i] + 7'h01 >= filt) begin
          next_fcnt[i] = '0;
          next_fstate[i] = sync2[i];
        end
      end
    end
    next_coast = (sync2[NUM_IN] == ctrl.coast_pol);
    next_estop = (sync2[NUM_IN+1] == ctrl.estop_pol);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_IN; i++) fcnt[i] <= '0;
      fstate <= '0;
      conditioned_inputs <= '0;
      coast_stop_active <= 1'b0;
      emergency_stop_active <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_IN; i++) fcnt[i] <= next_fcnt[i];
      fstate <= next_fstate;
      conditioned_inputs <= next_fstate ^ ctrl.inv_mask[NUM_IN-1:0];
      coast_stop_active <= next_coast;
      emergency_stop_active <= next_estop;
    end
  end

  // ***************************************************************
  // Pulse watchdog
  // ***************************************************************
  dio_wd_state_t wd_st, next_wd_st;
  logic [24:0] wd_pre, next_wd_pre;
  logic [15:0] wd_cnt, next_wd_cnt;
  logic wd_edge;

  always_comb begin
    wd_edge = sync2[NS-1] && !wd_prev;
    next_wd_st = wd_st;
    next_wd_pre = wd_pre + 25'd1;
    next_wd_cnt = wd_cnt;
    if (wd_pre >= 25'(WD_TICK - 1)) begin
      next_wd_pre = '0;
      next_wd_cnt = wd_cnt + 16'h0001;
    end
    case (wd_st)
      WD_RUN: begin
        if (wdt == 16'h0000 || wd_edge) begin
          next_wd_pre = '0;
          next_wd_cnt = '0;
        end else if (wd_cnt >= wdt) begin
          next_wd_st = ctrl.stop_mode ? WD_DECEL : WD_TRIP;
        end
      end
      WD_DECEL: begin
        if (drive_stopped) next_wd_st = WD_TRIP;
      end
      WD_TRIP: begin
        if (trip_clr) next_wd_st = WD_RUN;
      end
      default: next_wd_st = WD_RUN;
    endcase
    if (wd_st != WD_RUN) begin
      next_wd_pre = '0;
      next_wd_cnt = '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_st <= WD_RUN;
      wd_pre <= '0;
      wd_cnt <= '0;
      coast_stop_cmd <= 1'b0;
      decel_stop_cmd <= 1'b0;
      watchdog_trip_code <= 1'b0;
    end else begin
      wd_st <= next_wd_st;
      wd_pre <= next_wd_pre;
      wd_cnt <= next_wd_cnt;
      coast_stop_cmd <= (next_wd_st == WD_TRIP) && !ctrl.stop_mode;
      decel_stop_cmd <= (next_wd_st == WD_DECEL);
      watchdog_trip_code <= (next_wd_st == WD_TRIP);
    end
  end

  // ***************************************************************
  // Output simulation and analog channels
  // ***************************************************************
  logic [15:0] bench;
  logic signed [23:0] fa, fb;
  assign bench = combined_speed_mode ? main_frequency : max_frequency_setting;

  dio_chan #(.LPF_STEP(LPF_STEP)) u_cha (
    .hclk(hclk), .hresetn(hresetn), .adc(analog_input_one), .cfg(cha), .bench(bench),
    .freq(fa)
  );
  dio_chan #(.LPF_STEP(LPF_STEP)) u_chb (
    .hclk(hclk), .hresetn(hresetn), .adc(analog_input_two), .cfg(chb), .bench(bench),
    .freq(fb)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      relay_out <= 1'b0;
      digital_output_one <= 1'b0;
      digital_output_two <= 1'b0;
      analog_output_one <= '0;
      analog_output_two <= '0;
      freq_a <= '0;
      freq_b <= '0;
      reverse_a <= 1'b0;
      reverse_b <= 1'b0;
    end else begin
      // Force value 0 means active; forcing drops out as soon as the drive runs
      relay_out <= (sim_en[0] && drive_stopped) ? !sim_val[0] : relay_normal;
      digital_output_one <= (sim_en[1] && drive_stopped) ? !sim_val[1] : do_one_normal;
      digital_output_two <= (sim_en[2] && drive_stopped) ? !sim_val[2] : do_two_normal;
      analog_output_one <= (sim_en[3] && drive_stopped) ? ao_a : ao_one_normal;
      analog_output_two <= (sim_en[4] && drive_stopped) ? ao_b : ao_two_normal;
      freq_a <= fa;
      freq_b <= fb;
      reverse_a <= run_direction_setting ^ fa[23];
      reverse_b <= run_direction_setting ^ fb[23];
    end
  end
endmodule // dio_terminal_cond

// ---- testbench/dio_terminal_cond_assertions.sv ----
`timescale 1ns/1ps
module dio_terminal_cond_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic drive_stopped,
  input wire logic relay_normal,
  input wire logic relay_out,
  input wire logic [11:0] ao_one_normal,
  input wire logic [11:0] analog_output_one,
  input wire logic coast_stop_cmd,
  input wire logic decel_stop_cmd,
  input wire logic watchdog_trip_code
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ********
  // Checks
  // ********
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not OKAY");
  a_rdata_held: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
  a_relay_normal: assert property (!$past(drive_stopped) && $past(hresetn) |->
    relay_out == $past(relay_normal)) else $error("relay forced while running");
  a_ao_normal: assert property (!$past(drive_stopped) && $past(hresetn) |->
    analog_output_one == $past(ao_one_normal)) else $error("analog out forced while running");
  a_stop_excl: assert property (!(coast_stop_cmd && decel_stop_cmd))
    else $error("coast and decel stop together");
  a_coast_trip: assert property ($rose(coast_stop_cmd) |-> ##[0:2] watchdog_trip_code)
    else $error("coast stop without trip");
  a_decel_first: assert property (decel_stop_cmd && !drive_stopped |=> !watchdog_trip_code)
    else $error("trip before drive stopped");
  a_decel_trip: assert property ($fell(decel_stop_cmd) |-> ##[0:2] watchdog_trip_code)
    else $error("no trip after decel stop");
  c_coast: cover property ($rose(coast_stop_cmd));
  c_decel: cover property ($fell(decel_stop_cmd));
  c_forced: cover property (drive_stopped && relay_out != relay_normal);
endmodule // dio_terminal_cond_assertions
bind dio_terminal_cond dio_terminal_cond_assertions u_dio_terminal_cond_assertions (.hclk,
  .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .drive_stopped,
  .relay_normal, .relay_out, .ao_one_normal, .analog_output_one, .coast_stop_cmd,
  .decel_stop_cmd, .watchdog_trip_code);

// ---- testbench/dio_terminal_model.sv ----
`timescale 1ns/1ps
module dio_terminal_model (
  input wire logic hclk,
  input wire logic pulse_en,
  input wire logic [7:0] period,
  input wire logic [7:0] level,
  output logic watchdog_pulse_pin,
  output logic [7:0] digital_input_n
);
  logic [7:0] cnt = 8'h00;
  initial watchdog_pulse_pin = 1'b0;
  initial digital_input_n = 8'h00;
  // Controller keeps pulsing faster than the timeout; disabling it models a dead controller
  always @(posedge hclk) begin
    digital_input_n <= level;
    if (!pulse_en) begin
      cnt <= 8'h00;
      watchdog_pulse_pin <= 1'b0;
    end else begin
      cnt <= (cnt >= period - 8'h01) ? 8'h00 : cnt + 8'h01;
      watchdog_pulse_pin <= (cnt < (period >> 1));
    end
  end
endmodule // dio_terminal_model

// ---- testbench/dio_terminal_cond_tb_top.sv ----
`timescale 1ns/1ps
module dio_terminal_cond_tb_top import dio_pkg::*; ;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, pulse_en = 1;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, coast_stop_pin = 0, emergency_stop_pin = 0, drive_stopped = 0;
  logic combined_speed_mode = 0, run_direction_setting = 0, relay_normal = 0;
  logic do_one_normal = 0, do_two_normal = 0;
  logic [11:0] analog_input_one = 0, analog_input_two = 0, ao_one_normal = 0, ao_two_normal = 0;
  logic [15:0] main_frequency = 16'h07D0, max_frequency_setting = 16'h1388;
  logic [7:0] digital_input_n, conditioned_inputs, level = 0, m, v8, prev;
  logic watchdog_pulse_pin, coast_stop_active, emergency_stop_active, coast_stop_cmd;
  logic decel_stop_cmd, watchdog_trip_code, relay_out, digital_output_one, digital_output_two;
  logic reverse_a, reverse_b;
  logic [11:0] analog_output_one, analog_output_two, c2;
  logic signed [23:0] freq_a, freq_b;
  int mismatches = 0, n_checks = 0, seed = 32'h05a8dc4e, n;
  int fw[3] = '{0, 200, 3};
  int fe[3] = '{1, 100, 3};
  always #2.5 hclk = ~hclk;
  // Short tick and filter step keep watchdog and filter runs brief
  dio_terminal_cond #(.WD_TICK(20), .LPF_STEP(2)) u_dio_terminal_cond (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .digital_input_n, .coast_stop_pin, .emergency_stop_pin, .watchdog_pulse_pin,
    .analog_input_one, .analog_input_two, .drive_stopped, .combined_speed_mode,
    .main_frequency, .max_frequency_setting, .run_direction_setting, .relay_normal,
    .do_one_normal, .do_two_normal, .ao_one_normal, .ao_two_normal, .conditioned_inputs,
    .coast_stop_active, .emergency_stop_active, .coast_stop_cmd, .decel_stop_cmd,
    .watchdog_trip_code, .relay_out, .digital_output_one, .digital_output_two,
    .analog_output_one, .analog_output_two, .freq_a, .freq_b, .reverse_a, .reverse_b);
  dio_terminal_model u_dio_terminal_model (.hclk, .pulse_en, .period(8'h14), .level,
    .watchdog_pulse_pin, .digital_input_n);
  // ********
  // Tasks
  // ********
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task tick(input int c);
    repeat (c) @(posedge hclk);
  endtask
  task rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      stop_test;
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    rdy;
    htrans <= 2'b00;
    hsel <= 0;
    hwdata <= d;
    rdy;
    q = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    ahb(0, a, 32'h0);
    chk(q, e);
  endtask
  // Bounded wait for trip (dec=0) or decel command (dec=1)
  task waits(input bit dec, input int lim);
    n = 0;
    while (((dec ? decel_stop_cmd : watchdog_trip_code) !== 1'b1) && n < lim) begin
      @(posedge hclk);
      #1 n++;
    end
    if (n >= lim) begin
      mismatches++;
      stop_test;
    end
  endtask
  function automatic logic [23:0] ef(input int pct, input int g, input int b);
    return 24'(pct * g / 10 * b / 100);
  endfunction
  // ********
  // Sequence
  // ********
  initial begin
    tick(5);
    hresetn <= 1;
    rd(OFS_CTRL, 0);
    rd(OFS_WDT, 32'd100);
    rd(OFS_FILT, 32'd10);
    rd(8'(OFS_CHA + CH_V), 32'h03E8_0004);
    rd(8'(OFS_CHB + CH_G), 32'h0001_000A);
    rd(8'(OFS_CHB + CH_S), 32'h00C8_0064);
    rd(8'h80, 0);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_FILT, fw[i]);
      rd(OFS_FILT, fe[i]);
    end
    $display("test reset done");
    for (int p = 0; p < 2; p++) begin
      for (int v = 0; v < 2; v++) begin
        wr(OFS_CTRL, {30'h0, p[0], p[0]});
        @(posedge hclk);
        coast_stop_pin <= v[0];
        emergency_stop_pin <= !v[0];
        tick(4);
        #1 chk(coast_stop_active, v == p);
        chk(emergency_stop_active, v != p);
      end
    end
    m = $random(seed);
    prev = 0;
    wr(OFS_CTRL, {16'h0, m, 8'h0});
    for (int i = 0; i < 4; i++) begin
      @(posedge hclk);
      v8 = $random(seed);
      level <= v8;
      tick(3);
      #1 chk(conditioned_inputs, prev ^ m);
      tick(8);
      #1 chk(conditioned_inputs, v8 ^ m);
      prev = v8;
    end
    rd(OFS_DIAG, {22'h0, 2'b10, prev ^ m});
    @(posedge hclk);
    c2 = $random(seed);
    analog_input_two <= c2;
    tick(5);
    rd(OFS_MON_B, {20'h0, c2});
    $display("test inputs done");
    wr(OFS_WDT, 2);
    tick(200);
    #1 chk(watchdog_trip_code, 0);
    @(posedge hclk);
    pulse_en <= 0;
    waits(0, 80);
    chk(n >= 20, 1);
    tick(2);
    #1 chk(coast_stop_cmd, 1);
    @(posedge hclk);
    pulse_en <= 1;
    wr(OFS_CTRL, {16'h0, m, 8'h10});
    tick(3);
    #1 chk({watchdog_trip_code, coast_stop_cmd}, 0);
    wr(OFS_CTRL, {16'h0, m, 8'h04});
    @(posedge hclk);
    pulse_en <= 0;
    waits(1, 80);
    tick(5);
    #1 chk({watchdog_trip_code, decel_stop_cmd}, 2'b01);
    @(posedge hclk);
    drive_stopped <= 1;
    waits(0, 10);
    chk(coast_stop_cmd, 0);
    @(posedge hclk);
    pulse_en <= 1;
    wr(OFS_CTRL, {16'h0, m, 8'h10});
    $display("test watchdog done");
    wr(OFS_OSIM, 32'h1F);
    tick(2);
    #1 chk({relay_out, digital_output_one, digital_output_two}, 3'b111);
    wr(OFS_OSIM, 32'h71F);
    tick(2);
    #1 chk({relay_out, digital_output_one, digital_output_two}, 3'b000);
    for (int i = 0; i < 3; i++) wr(OFS_AOSIM, 1);
    wr(OFS_AOSIM, 2);
    wr(OFS_AOSIM, 8);
    rd(OFS_AOSIM, 2);
    #1 chk(analog_output_one, 2);
    chk(analog_output_two, 0);
    @(posedge hclk);
    drive_stopped <= 0;
    ao_one_normal <= $random(seed);
    relay_normal <= 1;
    wr(OFS_AOSIM, 1);
    rd(OFS_AOSIM, 2);
    #1 chk(analog_output_one, ao_one_normal);
    chk(relay_out, relay_normal);
    @(posedge hclk);
    drive_stopped <= 1;
    wr(OFS_OSIM, 0);
    tick(2);
    #1 chk(relay_out, 1);
    $display("test forcing done");
    wr(8'(OFS_CHA + CH_V), 32'h0320_0064);
    wr(8'(OFS_CHA + CH_S), 32'h00C8_0000);
    @(posedge hclk);
    analog_input_one <= 12'hFFF;
    tick(400);
    rd(OFS_MON_A, 32'hFFF);
    rd(OFS_FREQ_A, {8'h0, ef(100, 10, 5000)});
    @(posedge hclk);
    analog_input_one <= 0;
    tick(400);
    rd(OFS_FREQ_A, {8'h01, ef(-100, 10, 5000)});
    @(posedge hclk);
    run_direction_setting <= 1;
    tick(4);
    rd(OFS_FREQ_A, {8'h00, ef(-100, 10, 5000)});
    wr(8'(OFS_CHA + CH_G), 32'h0001_0014);
    tick(4);
    rd(OFS_FREQ_A, {8'h00, ef(-100, 20, 5000)});
    @(posedge hclk);
    combined_speed_mode <= 1;
    tick(4);
    rd(OFS_FREQ_A, {8'h00, ef(-100, 20, 2000)});
    $display("test analog done");
    wr(OFS_WDT, 0);
    @(posedge hclk);
    pulse_en <= 0;
    tick(300);
    #1 chk(watchdog_trip_code, 0);
    $display("test disable done");
    stop_test;
  end
endmodule // dio_terminal_cond_tb_top
